// file: rtc_regs.svh
// register offsets, field positions, reset values and counts for the rtc
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// register offsets on the special function register port
`define RTC_CTRL_ADDR 16'hFFB0
`define RTC_CNT3_ADDR 16'hFFB1
`define RTC_CNT2_ADDR 16'hFFB2
`define RTC_CNT1_ADDR 16'hFFB3
`define RTC_CNT0_ADDR 16'hFFB4
`define RTC_ACC2_ADDR 16'hFFB5
`define RTC_ACC1_ADDR 16'hFFB6
`define RTC_ACC0_ADDR 16'hFFB7
`define RTC_TRIM2_ADDR 16'hFFB8
`define RTC_TRIM1_ADDR 16'hFFB9
`define RTC_TRIM0_ADDR 16'hFFBA
`define RTC_OSC_ADDR 16'hFFBB
`define RTC_INT5_ADDR 16'hFF94

// control register fields
`define RTC_CTRL_LOAD_BIT 5
`define RTC_CTRL_CT_HI 4
`define RTC_CTRL_CT_LO 3
`define RTC_CTRL_RI_HI 2
`define RTC_CTRL_RI_LO 0
`define RTC_CTRL_RESET 8'h00
`define RTC_CTRL_WMASK 8'h3F

// interrupt control register fields
`define RTC_INT5_EN_BIT 5
`define RTC_INT5_FLAG_BIT 4

// oscillator control register field
`define RTC_OSC_DIS_BIT 0

// trim sign bit and period masks in half-second marks
`define RTC_TRIM_SIGN_BIT 23
`define RTC_ACC_CARRY_BIT 24
`define RTC_MASK_HALF 4'h0
`define RTC_MASK_1S 4'h1
`define RTC_MASK_2S 4'h3
`define RTC_MASK_4S 4'h7
`define RTC_MASK_8S 4'hF

// low-speed clock figures
`define RTC_LS_FREQ_HZ 32768
`define RTC_HALF_SEC_TICKS (`RTC_LS_FREQ_HZ / 2)
`define RTC_MCLK_DIV 2930

`endif

// file: rtc_pkg.sv
// types shared by the rtc modules
`default_nettype none
package rtc_pkg;

	// hardware watchdog states
	typedef enum logic {
		WD_IDLE,
		WD_ARMED
	} wd_state_t;

	typedef logic [7:0] sfr_byte_t;

endpackage : rtc_pkg
`default_nettype wire

// file: rtc_tick_if.sv
// tick carrier between the time base and the rtc core
`timescale 1ns/1ns
`default_nettype none
interface rtc_tick_if;
	logic osc_disable; // core asks for the divided master clock
	logic slow_tick; // one pulse per low-speed clock rising edge
	logic half_mark; // one pulse per half second

	modport source (
		input osc_disable,
		output slow_tick,
		output half_mark
	);
	modport sink (
		output osc_disable,
		input slow_tick,
		input half_mark
	);
endinterface : rtc_tick_if
`default_nettype wire

// file: rtc_timebase.sv
// low-speed clock selection, divider and half-second time marks
`timescale 1ns/1ns
`default_nettype none
`include "rtc_regs.svh"
module rtc_timebase
	import rtc_pkg::*;
#(
	parameter int unsigned MCLK_DIV = `RTC_MCLK_DIV,
	parameter int unsigned HALF_TICKS = `RTC_HALF_SEC_TICKS
) (
	// clock and synchronised reset
	input wire logic clock,
	input wire logic rst_sync_n,
	// crystal oscillator output, synchronous to clock
	input wire logic xtal_32k,
	// ticks to the core
	rtc_tick_if.source tick
);

	// refuse counts the counters cannot hold
	initial begin
		if (MCLK_DIV < 2 || MCLK_DIV > 65535 || HALF_TICKS < 1 ||
			HALF_TICKS > 65536) begin
			$error("rtc_timebase: divider or tick count out of range");
		end
	end

	logic xtal_prev_r; // crystal level one cycle ago
	logic [15:0] div_cnt_r; // master clock divider
	logic slow_tick_r; // low-speed edge pulse
	logic [15:0] half_cnt_r; // low-speed edges within a half second
	logic half_mark_r; // half-second pulse

	// remember the crystal level for edge detection
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			xtal_prev_r <= 1'b0;
		end else begin
			xtal_prev_r <= xtal_32k;
		end
	end

	// divided master clock stands in when the crystal is off
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			div_cnt_r <= 16'h0000;
		end else if (!tick.osc_disable ||
			div_cnt_r == 16'(MCLK_DIV - 1)) begin
			div_cnt_r <= 16'h0000; // held idle while the crystal runs
		end else begin
			div_cnt_r <= div_cnt_r + 16'h0001;
		end
	end

	// one pulse per low-speed rising edge from whichever source
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			slow_tick_r <= 1'b0;
		end else if (tick.osc_disable) begin
			slow_tick_r <= (div_cnt_r == 16'(MCLK_DIV - 1));
		end else begin
			slow_tick_r <= xtal_32k & ~xtal_prev_r;
		end
	end

	// count low-speed edges into half-second marks
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			half_cnt_r <= 16'h0000;
			half_mark_r <= 1'b0;
		end else begin
			half_mark_r <= 1'b0;
			if (slow_tick_r) begin
				if (half_cnt_r == 16'(HALF_TICKS - 1)) begin
					half_cnt_r <= 16'h0000;
					half_mark_r <= 1'b1;
				end else begin
					half_cnt_r <= half_cnt_r + 16'h0001;
				end
			end
		end
	end

	assign tick.slow_tick = slow_tick_r;
	assign tick.half_mark = half_mark_r;

endmodule : rtc_timebase
`default_nettype wire

// file: rtc_trim_wdt.sv
// real-time clock core: time counter, trim, periodic interrupt, watchdog
`timescale 1ns/1ns
`default_nettype none
`include "rtc_regs.svh"
module rtc_trim_wdt
	import rtc_pkg::*;
#(
	parameter int unsigned MCLK_DIV = `RTC_MCLK_DIV,
	parameter int unsigned HALF_TICKS = `RTC_HALF_SEC_TICKS
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// special function register port
	input wire logic [15:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// low-speed crystal, synchronous to clock
	input wire logic xtal_32k,
	// to the processor core and reset logic
	output logic irq_ext5,
	output logic wdt_reset_req
);

	// refuse counts the watchdog counter cannot hold
	initial begin
		// the watchdog counter is sixteen bits wide
		if (HALF_TICKS < 1 || HALF_TICKS > 65536) begin
			$error("rtc_trim_wdt: half-second tick count out of range");
		end
	end

	// period mask from the count-select field
	function automatic logic [3:0] count_mask(input logic [1:0] sel);
		// codes 00 and 01 both mean one second
		unique case (sel)
			2'h2: count_mask = `RTC_MASK_HALF;
			2'h3: count_mask = `RTC_MASK_2S;
			default: count_mask = `RTC_MASK_1S; // 0x
		endcase
	endfunction : count_mask

	// period mask from the interrupt interval field
	function automatic logic [3:0] irq_mask(input logic [2:0] sel);
		// any code with the top bit clear means one second
		unique case (sel)
			3'h4: irq_mask = `RTC_MASK_HALF;
			3'h5: irq_mask = `RTC_MASK_2S;
			3'h6: irq_mask = `RTC_MASK_4S;
			3'h7: irq_mask = `RTC_MASK_8S;
			default: irq_mask = `RTC_MASK_1S; // 0xx
		endcase
	endfunction : irq_mask

	// replace one byte of a wider word
	function automatic logic [31:0] put_byte(input logic [31:0] word,
		input logic [1:0] lane, input sfr_byte_t data);
		logic [31:0] res;
		res = word;
		res[8 * lane +: 8] = data;
		put_byte = res;
	endfunction : put_byte

	// interrupt control byte as software sees it; spare bits read zero
	function automatic sfr_byte_t int5_byte(input logic en, input logic flag);
		sfr_byte_t res;
		res = 8'h00;
		res[`RTC_INT5_EN_BIT] = en;
		res[`RTC_INT5_FLAG_BIT] = flag;
		int5_byte = res;
	endfunction : int5_byte

	// reset release through two flops
	logic rst_meta_r; // first stage, read only by the second
	logic rst_sync_n; // reset copy for the rest of the design

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			// release ripples through two flops
			rst_meta_r <= 1'b1;
			rst_sync_n <= rst_meta_r;
		end
	end

	// time base
	rtc_tick_if tick ();

	rtc_timebase #(
		.MCLK_DIV(MCLK_DIV),
		.HALF_TICKS(HALF_TICKS)
	) u_timebase (
		.clock(clock),
		.rst_sync_n(rst_sync_n),
		.xtal_32k(xtal_32k),
		.tick(tick)
	);

	// software-visible state
	logic [7:0] ctrl_r; // clock_control_reg
	logic osc_dis_r; // crystal oscillator disabled
	logic [31:0] cnt_stage_r; // staged time counter
	logic [31:0] acc_stage_r; // staged accumulator, low 24 bits used
	logic [31:0] trim_stage_r; // staged trim, low 24 bits used
	logic irq_en_r; // periodic_irq_enable
	logic irq_flag_r; // periodic_irq_flag
	logic [7:0] sfr_rdata_r; // registered read data

	// live rtc state
	logic [31:0] time_counter_r; // running time count
	logic [23:0] trim_accumulator_r; // running accumulator
	logic [23:0] trim_value_r; // trim in use
	logic [3:0] hs_cnt_r; // free-running half-second count

	// hardware watchdog state
	wd_state_t wd_state_r;
	logic [15:0] wd_cnt_r; // low-speed ticks since arming
	logic wdt_reset_r; // one-cycle reset request

	// decoded strobes and events
	logic load_now; // staged values taken this cycle
	logic advance; // time counter period elapsed
	logic irq_event; // periodic interrupt occurs
	logic service_rd; // read of the interrupt control register
	logic [24:0] acc_sum; // accumulator plus trim magnitude

	assign tick.osc_disable = osc_dis_r;
	assign service_rd = sfr_rd && (sfr_addr == `RTC_INT5_ADDR);

	// load pending and low-speed edge together
	assign load_now = ctrl_r[`RTC_CTRL_LOAD_BIT] && tick.slow_tick;

	// counter advances on the marks that close a count period
	assign advance = tick.half_mark && ((hs_cnt_r &
		count_mask(ctrl_r[`RTC_CTRL_CT_HI:`RTC_CTRL_CT_LO])) ==
		count_mask(ctrl_r[`RTC_CTRL_CT_HI:`RTC_CTRL_CT_LO]));

	// interrupt on the marks that close an interval
	assign irq_event = tick.half_mark && ((hs_cnt_r &
		irq_mask(ctrl_r[`RTC_CTRL_RI_HI:`RTC_CTRL_RI_LO])) ==
		irq_mask(ctrl_r[`RTC_CTRL_RI_HI:`RTC_CTRL_RI_LO]));

	// magnitude only; the sign decides what an overflow does
	assign acc_sum = {1'b0, trim_accumulator_r} +
		{2'b00, trim_value_r[`RTC_TRIM_SIGN_BIT-1:0]};

	// half-second phase shared by counter and interrupt periods
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			hs_cnt_r <= 4'h0;
		end else if (tick.half_mark) begin
			// wraps at sixteen marks, the longest interval
			hs_cnt_r <= hs_cnt_r + 4'h1;
		end
	end

	// control register; load bit clears itself once taken
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// no load pending, one-second count and interval
			ctrl_r <= `RTC_CTRL_RESET;
		end else if (sfr_wr && sfr_addr == `RTC_CTRL_ADDR) begin
			// top two bits are spare and always read zero
			ctrl_r <= sfr_wdata & `RTC_CTRL_WMASK;
		end else if (load_now) begin
			// load taken: software sees the bit drop
			ctrl_r[`RTC_CTRL_LOAD_BIT] <= 1'b0;
		end
	end

	// oscillator control
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// crystal runs after reset
			osc_dis_r <= 1'b0;
		end else if (sfr_wr && sfr_addr == `RTC_OSC_ADDR) begin
			// set: run from the divided master clock
			osc_dis_r <= sfr_wdata[`RTC_OSC_DIS_BIT];
		end
	end

	// staging registers; writes never touch the running clock
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// staged values start at zero
			cnt_stage_r <= 32'h0000_0000;
			acc_stage_r <= 32'h0000_0000;
			trim_stage_r <= 32'h0000_0000;
		end else if (sfr_wr) begin
			// each byte lands in its own lane of the staged word
			unique case (sfr_addr)
				`RTC_CNT3_ADDR: cnt_stage_r <= put_byte(cnt_stage_r, 2'h3, sfr_wdata);
				`RTC_CNT2_ADDR: cnt_stage_r <= put_byte(cnt_stage_r, 2'h2, sfr_wdata);
				`RTC_CNT1_ADDR: cnt_stage_r <= put_byte(cnt_stage_r, 2'h1, sfr_wdata);
				`RTC_CNT0_ADDR: cnt_stage_r <= put_byte(cnt_stage_r, 2'h0, sfr_wdata);
				`RTC_ACC2_ADDR: acc_stage_r <= put_byte(acc_stage_r, 2'h2, sfr_wdata);
				`RTC_ACC1_ADDR: acc_stage_r <= put_byte(acc_stage_r, 2'h1, sfr_wdata);
				`RTC_ACC0_ADDR: acc_stage_r <= put_byte(acc_stage_r, 2'h0, sfr_wdata);
				`RTC_TRIM2_ADDR: trim_stage_r <= put_byte(trim_stage_r, 2'h2, sfr_wdata);
				`RTC_TRIM1_ADDR: trim_stage_r <= put_byte(trim_stage_r, 2'h1, sfr_wdata);
				`RTC_TRIM0_ADDR: trim_stage_r <= put_byte(trim_stage_r, 2'h0, sfr_wdata);
				default: ; // other addresses belong to other blocks
			endcase
		end
	end

	// running counter and accumulator; a load beats an advance
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			time_counter_r <= 32'h0000_0000;
			trim_accumulator_r <= 24'h00_0000;
			trim_value_r <= 24'h00_0000;
		end else if (load_now) begin
			// all three values go live on the same tick
			time_counter_r <= cnt_stage_r;
			trim_accumulator_r <= acc_stage_r[23:0];
			trim_value_r <= trim_stage_r[23:0];
		end else if (advance) begin
			// accumulator runs at the counter's rate
			trim_accumulator_r <= acc_sum[23:0];
			if (!acc_sum[`RTC_ACC_CARRY_BIT]) begin
				time_counter_r <= time_counter_r + 32'h0000_0001;
			end else if (!trim_value_r[`RTC_TRIM_SIGN_BIT]) begin
				time_counter_r <= time_counter_r + 32'h0000_0002;
			end
			// negative trim overflow: this advance is skipped
		end
	end

	// interrupt enable and flag; a new event beats the clearing read
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_en_r <= 1'b0;
			irq_flag_r <= 1'b0;
		end else begin
			// only the enable bit is writable here
			if (sfr_wr && sfr_addr == `RTC_INT5_ADDR) begin
				irq_en_r <= sfr_wdata[`RTC_INT5_EN_BIT];
			end
			// set beats clear so an event is never lost
			if (irq_event) begin
				irq_flag_r <= 1'b1;
			end else if (service_rd) begin
				irq_flag_r <= 1'b0;
			end
		end
	end

	// hardware watchdog: half a second of low-speed ticks per interrupt
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			// idle, window not running
			wd_state_r <= WD_IDLE;
			wd_cnt_r <= 16'h0000;
			wdt_reset_r <= 1'b0;
		end else begin
			wdt_reset_r <= 1'b0;
			unique case (wd_state_r)
				WD_IDLE: begin
					// an interrupt taken while enabled starts the window
					if (irq_en_r && irq_event) begin
						wd_state_r <= WD_ARMED;
						wd_cnt_r <= 16'h0000;
					end
				end
				WD_ARMED: begin
					// masking the interrupt stops the watchdog at once
					if (!irq_en_r) begin
						wd_state_r <= WD_IDLE;
					end else if (irq_event) begin
						// keep timing the oldest unserviced interrupt
					end else if (service_rd) begin
						wd_state_r <= WD_IDLE;
					end else if (tick.slow_tick) begin
						if (wd_cnt_r == 16'(HALF_TICKS - 1)) begin
							// window ran out with the interrupt still pending
							wd_state_r <= WD_IDLE;
							wdt_reset_r <= 1'b1;
						end else begin
							wd_cnt_r <= wd_cnt_r + 16'h0001;
						end
					end
				end
			endcase
		end
	end

	// read data, one cycle after the strobe; live state is shown except trim, which reads its staged value
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sfr_rdata_r <= 8'h00;
		end else if (sfr_rd) begin
			// count and accumulator read live; no byte latch
			unique case (sfr_addr)
				`RTC_CTRL_ADDR: sfr_rdata_r <= ctrl_r;
				`RTC_CNT3_ADDR: sfr_rdata_r <= time_counter_r[31:24];
				`RTC_CNT2_ADDR: sfr_rdata_r <= time_counter_r[23:16];
				`RTC_CNT1_ADDR: sfr_rdata_r <= time_counter_r[15:8];
				`RTC_CNT0_ADDR: sfr_rdata_r <= time_counter_r[7:0];
				`RTC_ACC2_ADDR: sfr_rdata_r <= trim_accumulator_r[23:16];
				`RTC_ACC1_ADDR: sfr_rdata_r <= trim_accumulator_r[15:8];
				`RTC_ACC0_ADDR: sfr_rdata_r <= trim_accumulator_r[7:0];
				`RTC_TRIM2_ADDR: sfr_rdata_r <= trim_stage_r[23:16];
				`RTC_TRIM1_ADDR: sfr_rdata_r <= trim_stage_r[15:8];
				`RTC_TRIM0_ADDR: sfr_rdata_r <= trim_stage_r[7:0];
				`RTC_OSC_ADDR: sfr_rdata_r <= {7'h00, osc_dis_r};
				`RTC_INT5_ADDR: sfr_rdata_r <= int5_byte(irq_en_r, irq_flag_r);
				default: sfr_rdata_r <= 8'h00; // unmapped reads as zero
			endcase
		end
	end

	// read data and watchdog request straight from registers
	assign sfr_rdata = sfr_rdata_r;
	// level output; a masked flag stays invisible to the core
	assign irq_ext5 = irq_en_r & irq_flag_r;
	assign wdt_reset_req = wdt_reset_r;

endmodule : rtc_trim_wdt
`default_nettype wire

// file: rtc_trim_wdt_sva.sv
// port-level checks for the rtc core
`timescale 1ns/1ns
`default_nettype none
`include "rtc_regs.svh"
module rtc_trim_wdt_sva (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [15:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// crystal and outputs
	input wire logic xtal_32k,
	input wire logic irq_ext5,
	input wire logic wdt_reset_req
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic rd_int5; // service read of the interrupt register
	logic wr_int5; // write of the interrupt register
	assign rd_int5 = sfr_rd && sfr_addr == `RTC_INT5_ADDR;
	assign wr_int5 = sfr_wr && sfr_addr == `RTC_INT5_ADDR;
	// a named sequence keeps the back-to-back trim access readable
	sequence trim_wr_rd;
		sfr_wr && sfr_addr == `RTC_TRIM0_ADDR
		##1 sfr_rd && sfr_addr == `RTC_TRIM0_ADDR;
	endsequence
	a_ctrl_top_zero: assert property (
		sfr_rd && sfr_addr == `RTC_CTRL_ADDR |=> sfr_rdata[7:6] == 2'b00)
		else $error("control top bits not zero");
	a_int5_layout: assert property (
		rd_int5 |=> sfr_rdata[3:0] == 4'h0 && sfr_rdata[7:6] == 2'b00)
		else $error("interrupt register spare bits set");
	a_irq_shows_bits: assert property (
		rd_int5 && irq_ext5 |=> sfr_rdata[5:4] == 2'b11)
		else $error("pending irq not shown as enable and flag");
	a_irq_level_held: assert property (
		irq_ext5 && !rd_int5 && !wr_int5 |=> irq_ext5)
		else $error("irq dropped without service");
	a_wdt_single_pulse: assert property (
		wdt_reset_req |=> !wdt_reset_req)
		else $error("watchdog request longer than one cycle");
	a_wdt_needs_irq: assert property (
		$rose(wdt_reset_req) |-> irq_ext5 && $past(irq_ext5, 4))
		else $error("watchdog fired without pending irq");
	a_service_no_wdt: assert property (
		rd_int5 && irq_ext5 |=> !wdt_reset_req [*8])
		else $error("watchdog fired right after service");
	a_trim_readback: assert property (
		trim_wr_rd |=> sfr_rdata == $past(sfr_wdata, 2))
		else $error("staged trim byte not read back");
	a_reset_quiet: assert property (disable iff (1'b0)
		!rst_n |-> !irq_ext5 && !wdt_reset_req)
		else $error("output active during reset");
	// main scenarios reached
	c_wdt: cover property (wdt_reset_req);
	c_service: cover property (rd_int5 && irq_ext5);
	c_trim: cover property (trim_wr_rd);
endmodule : rtc_trim_wdt_sva
bind rtc_trim_wdt rtc_trim_wdt_sva u_sva (.clock(clock), .rst_n(rst_n),
	.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .xtal_32k(xtal_32k),
	.irq_ext5(irq_ext5), .wdt_reset_req(wdt_reset_req));
`default_nettype wire

// file: rtc_xtal_model.sv
// crystal stand-in, synchronous to clock, stopped when not running
`timescale 1ns/1ns
`default_nettype none
module rtc_xtal_model #(
	parameter int HALF = 3
) (
	// clock and run control
	input wire logic clock,
	input wire logic run,
	// crystal level
	output logic xtal_32k
);
	int n = 0; // clocks into the current half period
	logic lvl = 1'b0; // crystal level, low until started
	assign xtal_32k = lvl;
	// a stopped oscillator parks low, so no stray edge reaches the rtc
	always @(posedge clock) begin
		if (!run) begin
			n <= 0;
			lvl <= 1'b0;
		end else if (n == HALF - 1) begin
			n <= 0;
			lvl <= ~lvl;
		end else begin
			n <= n + 1;
		end
	end
endmodule : rtc_xtal_model
`default_nettype wire

// file: rtc_trim_wdt_test.sv
// self-checking bench for the rtc core
`timescale 1ns/1ns
`default_nettype none
`include "rtc_regs.svh"
module rtc_trim_wdt_test;
	import rtc_pkg::*;
	logic clock, rst_n, sfr_wr, sfr_rd, xrun, xtal_32k, irq_ext5, wdt_reset_req;
	logic [15:0] sfr_addr; // register address
	logic [7:0] sfr_wdata, sfr_rdata, rd; // bus data and last byte read
	logic [31:0] v, c0, c1; // multi-byte reads
	int mismatches, n_checks, k, t0, t1;
	int cyc = 0, n_wdt = 0; // cycle stamp and watchdog pulses
	// interval codes with their period in half-second marks
	logic [2:0] codes [6] = '{3'b100, 3'b000, 3'b011, 3'b101, 3'b110, 3'b111};
	int marks [6] = '{1, 2, 2, 4, 8, 16};
	// count selects with the advances seen over four marks
	logic [1:0] sels [4] = '{2'b10, 2'b00, 2'b01, 2'b11};
	int steps [4] = '{4, 2, 2, 1};
	// short counts: one mark is 4 slow ticks of 4 clocks
	rtc_trim_wdt #(.MCLK_DIV(4), .HALF_TICKS(4)) u_dut (.clock(clock),
		.rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.xtal_32k(xtal_32k), .irq_ext5(irq_ext5),
		.wdt_reset_req(wdt_reset_req));
	rtc_xtal_model #(.HALF(3)) u_xtal (.clock(clock), .run(xrun),
		.xtal_32k(xtal_32k));
	// 250 MHz clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// cycle stamp and watchdog pulse count
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (wdt_reset_req === 1'b1) n_wdt <= n_wdt + 1;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one-cycle write strobe; an edge passes between two writes in a row
	task automatic wr(logic [15:0] a, logic [7:0] d);
		if (sfr_wr === 1'b1) @(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clock);
		sfr_wr <= 1'b0;
	endtask : wr
	// read data lands one cycle after the strobe
	task automatic rdb(logic [15:0] a, output logic [7:0] d);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clock);
		sfr_rd <= 1'b0;
		@(posedge clock);
		d = sfr_rdata;
	endtask : rdb
	// multi-byte values sit most significant byte first
	task automatic wrn(logic [15:0] a, int n, logic [31:0] x);
		for (int i = 0; i < n; i++) wr(a + 16'(i), x[8 * (n - 1 - i) +: 8]);
	endtask : wrn
	task automatic rdn(logic [15:0] a, int n, output logic [31:0] x);
		logic [7:0] d;
		x = 32'h0;
		for (int i = 0; i < n; i++) begin
			rdb(a + 16'(i), d);
			x = {x[23:0], d};
		end
	endtask : rdn
	// wait for the irq, stamp it, then service it at once
	task automatic irq_sync(output int t);
		int j;
		for (j = 0; j < 2000 && irq_ext5 !== 1'b1; j++) @(posedge clock);
		if (j == 2000) begin
			mismatches++;
			tally_and_finish();
		end
		t = cyc;
		rdb(`RTC_INT5_ADDR, rd);
		check("irq bits", rd[5:4], 2'b11);
	endtask : irq_sync
	// stage count, accumulator near overflow and a trim, then load
	task automatic trim_case(logic [31:0] tr, logic [31:0] ec);
		wr(`RTC_INT5_ADDR, 8'h00);
		wrn(`RTC_CNT3_ADDR, 4, 32'h100);
		wrn(`RTC_ACC2_ADDR, 3, 32'hFFFFFF);
		wrn(`RTC_TRIM2_ADDR, 3, tr);
		wr(`RTC_INT5_ADDR, 8'h20);
		rdb(`RTC_INT5_ADDR, rd);
		irq_sync(t0);
		wr(`RTC_CTRL_ADDR, 8'h34);
		irq_sync(t0);
		rdn(`RTC_CNT3_ADDR, 4, v);
		check("trimmed count", v, ec);
		rdn(`RTC_ACC2_ADDR, 3, v);
		check("accumulator", v, 32'h0);
		rdb(`RTC_CTRL_ADDR, rd);
		check("load done", rd, 8'h14);
	endtask : trim_case
	initial begin
		mismatches = 0;
		n_checks = 0;
		rst_n = 1'b0;
		sfr_addr = 16'h0000;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		xrun = 1'b0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rdb(`RTC_CTRL_ADDR, rd);
		check("ctrl reset", rd, 8'h00);
		rdb(`RTC_INT5_ADDR, rd);
		check("int5 reset", rd, 8'h00);
		wr(16'hFFC0, 8'hFF);
		rdb(16'hFFC0, rd);
		check("unmapped", rd, 8'h00);
		wrn(`RTC_TRIM2_ADDR, 3, 32'h6FD);
		rdb(`RTC_TRIM0_ADDR, rd);
		check("trim low", rd, 8'hFD);
		rdn(`RTC_TRIM2_ADDR, 3, v);
		check("trim", v, 32'h6FD);
		// divided master clock, irq enabled
		wr(`RTC_OSC_ADDR, 8'h01);
		wr(`RTC_INT5_ADDR, 8'h20);
		foreach (codes[i]) begin
			wr(`RTC_CTRL_ADDR, {5'b00010, codes[i]});
			irq_sync(t0);
			irq_sync(t1);
			check("interval", t1 - t0, 16 * marks[i]);
		end
		foreach (sels[i]) begin
			wr(`RTC_CTRL_ADDR, {3'b000, sels[i], 3'b100});
			irq_sync(t0);
			rdn(`RTC_CNT3_ADDR, 4, c0);
			repeat (4) irq_sync(t0);
			rdn(`RTC_CNT3_ADDR, 4, c1);
			check("advance", c1 - c0, steps[i]);
		end
		trim_case(32'h000001, 32'h102);
		trim_case(32'h800001, 32'h100);
		// masked: flag still sets, no irq, no watchdog
		wr(`RTC_INT5_ADDR, 8'h00);
		repeat (100) @(posedge clock);
		check("masked irq", irq_ext5, 1'b0);
		check("no wdt", n_wdt, 0);
		rdb(`RTC_INT5_ADDR, rd);
		check("flag only", rd, 8'h10);
		// leave an irq unserviced
		wr(`RTC_INT5_ADDR, 8'h20);
		rdb(`RTC_INT5_ADDR, rd);
		irq_sync(t0);
		for (k = 0; k < 2000 && irq_ext5 !== 1'b1; k++) @(posedge clock);
		if (k == 2000) begin
			mismatches++;
			tally_and_finish();
		end
		for (k = 0; k < 64 && n_wdt == 0; k++) @(posedge clock);
		check("wdt delay", k >= 12 && k <= 20, 1'b1);
		if (k == 64) tally_and_finish();
		// back to the crystal: a mark is 4 edges of 6 clocks
		wr(`RTC_OSC_ADDR, 8'h00);
		xrun <= 1'b1;
		irq_sync(t0);
		irq_sync(t0);
		irq_sync(t1);
		check("crystal mark", t1 - t0, 24);
		tally_and_finish();
	end
endmodule : rtc_trim_wdt_test
`default_nettype wire
